/* read_throttle_pkg.sv */
// Operation
// (R1) global read threshold equals thirteen-bit field times two to the fifteenth
// (R2) counter throttling lasts multiplier (0..63) global sampling windows once invoked
// (R3) monitor window is the seven-bit field padded with four zero bits
// (R4) while active, count hexwords per window; block reads at cap until window end
// (R5) per-window cap comes from a twelve-bit field, 0 to 4095 hexwords
// (R6) mode 00 disables both counter and thermal-signal invocation
// (R7) mode 01 throttles for as long as thermal request stays high
// (R8) thermal request falling in mode 01 stops throttling and clears window counters
// (R9) thermal request has no effect unless mode 01 is selected
// (R10) mode 10 runs global read counter and throttles on reaching threshold
// (R11) start bit written 0 stops throttling and clears window counters
// (R12) start bit written 1 throttles until software clears it
// (R13) sampling window length is programmable; global counter restarts each window
// (R14) mode 11 is reserved and behaves as disabled
package read_throttle_pkg;

  // ==========================================================
  // register map (byte addresses, one 32-bit word each)
  // ==========================================================
  localparam logic [11:0] CTRL_LO_OFS  = 12'h058;
  localparam logic [11:0] CTRL_HI_OFS  = 12'h05C;
  localparam logic [11:0] SAMPLE_WIN_OFS = 12'h060;
  localparam logic [11:0] STATUS_OFS   = 12'h064;

  // ==========================================================
  // read_throttle_control field layout (64-bit register)
  // ==========================================================
  localparam int THRESH_LSB = 28;
  localparam int THRESH_MSB = 40;
  localparam int DUR_LSB    = 22;
  localparam int DUR_MSB    = 27;
  localparam int WIN_LSB    = 15;
  localparam int WIN_MSB    = 21;
  localparam int CAP_LSB    = 3;
  localparam int CAP_MSB    = 14;
  localparam int MODE_LSB   = 1;
  localparam int MODE_MSB   = 2;
  localparam int GO_BIT     = 0;

  localparam int THRESH_SHIFT = 15;
  localparam int WIN_SHIFT    = 4;

  // bits 63:41 are reserved and read as zero
  localparam logic [63:0] CTRL_WR_MASK = 64'h0000_01FF_FFFF_FFFF;
  localparam logic [63:0] CTRL_RESET   = 64'h0000_0000_0000_0000;
  localparam logic [31:0] SAMPLE_WIN_RESET = 32'h0000_0000;

  // status word bit positions
  localparam int ST_ACTIVE = 0;
  localparam int ST_BLOCK  = 1;
  localparam int ST_CNTR   = 2;
  localparam int ST_DUR_LSB = 8;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_THERMAL,
    MODE_COUNTER,
    MODE_RESERVED
  } mode_e;

endpackage

/* monitor_if.sv */
interface monitor_if;
  logic        active;
  logic        hexword;
  logic [10:0] win_len;
  logic [11:0] cap;
  logic        block;
  logic [11:0] hcount;

  modport ctl (output active, output hexword, output win_len, output cap,
               input block, input hcount);
  modport mon (input active, input hexword, input win_len, input cap,
               output block, output hcount);
endinterface

/* window_monitor.sv */
module window_monitor (
  input  wire logic pclk,
  input  wire logic presetn,
  monitor_if.mon    mif
);

  typedef struct packed {
    logic [10:0] wcnt;
    logic [11:0] hcnt;
    logic        block;
  } mon_s;

  mon_s st_q;
  mon_s st_d;
  logic wend;

  // ==========================================================
  // window and hexword counting
  // ==========================================================
  always_comb begin
    st_d = st_q;
    // a zero-length window ends every cycle
    wend = ({1'b0, st_q.wcnt} + 12'h001) >= {1'b0, mif.win_len};
    // (R8) idle clears counters
    if (!mif.active) begin
      st_d.wcnt  = 11'h000;
      st_d.hcnt  = 12'h000;
      st_d.block = 1'b0;
    end else begin
      // (R3) window length count
      st_d.wcnt = wend ? 11'h000 : st_q.wcnt + 11'h001;
      if (wend) begin
        st_d.hcnt = 12'h000;
      end else if (mif.hexword && st_q.hcnt != 12'hFFF) begin
        st_d.hcnt = st_q.hcnt + 12'h001;
      end
      // (R4) cap reached blocks reads
      st_d.block = st_d.hcnt >= mif.cap;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign mif.block  = st_q.block;
  assign mif.hcount = st_q.hcnt;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idle_counters_clear: assert property ( // (R11)
    !mif.active |=> st_q.hcnt == 12'h000 && st_q.wcnt == 11'h000 && !st_q.block)
    else $error("counters not cleared while idle");
  a_window_bound: assert property ( // (R3)
    ($stable(mif.win_len) && st_q.wcnt != 11'h000) |-> st_q.wcnt < mif.win_len)
    else $error("window counter ran past window length");
  a_block_needs_cap: assert property ( // (R4)
    st_q.block |-> st_q.hcnt >= $past(mif.cap) && $past(mif.active))
    else $error("block raised below cap or while idle");
endmodule

/* dram_read_throttle.sv */
module dram_read_throttle (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        thermal_on,
  input  wire logic        rd_hexword,
  output logic             rd_block,
  output logic             throttle_active
);

  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic [63:0] ctrl;
    logic [31:0] swin;
    logic [31:0] swin_cnt;
    logic [27:0] gread;
    logic [5:0]  dur;
    logic        hit;
    logic        active;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } top_s;

  top_s st_q;
  top_s st_d;

  monitor_if mif ();

  window_monitor u_mon (
    .pclk    (pclk),
    .presetn (presetn),
    .mif     (mif)
  );

  // ==========================================================
  // field extraction
  // ==========================================================
  logic [12:0] thresh_field;
  logic [27:0] thresh;
  logic [5:0]  dur_mult;
  logic [6:0]  win_field;
  logic [1:0]  mode;
  logic        go;
  logic        swin_end;
  logic        reach;
  logic [27:0] gread_inc;

  assign thresh_field = st_q.ctrl[read_throttle_pkg::THRESH_MSB:read_throttle_pkg::THRESH_LSB];
  // (R1) threshold scaled by 2^15
  assign thresh       = {thresh_field, 15'h0000};
  // (R2) duration multiplier
  assign dur_mult     = st_q.ctrl[read_throttle_pkg::DUR_MSB:read_throttle_pkg::DUR_LSB];
  assign win_field    = st_q.ctrl[read_throttle_pkg::WIN_MSB:read_throttle_pkg::WIN_LSB];
  assign mode         = st_q.ctrl[read_throttle_pkg::MODE_MSB:read_throttle_pkg::MODE_LSB];
  assign go           = st_q.ctrl[read_throttle_pkg::GO_BIT];

  // ==========================================================
  // monitor hookup
  // ==========================================================
  assign mif.active  = st_q.active;
  assign mif.hexword = rd_hexword;
  // (R3) pad window field with four zeros
  assign mif.win_len = {win_field, 4'h0};
  // (R5) cap field
  assign mif.cap     = st_q.ctrl[read_throttle_pkg::CAP_MSB:read_throttle_pkg::CAP_LSB];

  // global sampling window ends; a zero length is treated as one cycle
  assign swin_end  = (st_q.swin_cnt + 32'h0000_0001) >= st_q.swin;
  // saturate so a long window cannot wrap the volume count back under threshold
  assign gread_inc = (rd_hexword && st_q.gread != 28'hFFF_FFFF) ? st_q.gread + 28'h000_0001
                                                                 : st_q.gread;
  // (R10) threshold reached, only when not already in effect
  assign reach     = (mode == read_throttle_pkg::MODE_COUNTER) && !st_q.hit &&
                     st_q.dur == 6'h00 && gread_inc >= thresh;

  // ==========================================================
  // next state: apb slave, counter mechanism, activation
  // ==========================================================
  always_comb begin
    logic [63:0] wr_mask;
    logic [31:0] bytes;
    logic        hit_addr;
    wr_mask  = '0;
    bytes    = '0;
    hit_addr = 1'b0;
    st_d     = st_q;

    // setup phase: decode and capture read data, answer in the access phase
    st_d.pready  = psel && !penable;
    st_d.pslverr = 1'b0;
    if (psel && !penable) begin
      if (paddr == read_throttle_pkg::CTRL_LO_OFS) begin
        st_d.prdata = st_q.ctrl[31:0];
      end else if (paddr == read_throttle_pkg::CTRL_HI_OFS) begin
        st_d.prdata = st_q.ctrl[63:32];
      end else if (paddr == read_throttle_pkg::SAMPLE_WIN_OFS) begin
        st_d.prdata = st_q.swin;
      end else if (paddr == read_throttle_pkg::STATUS_OFS) begin
        st_d.prdata = '0;
        st_d.prdata[read_throttle_pkg::ST_ACTIVE] = st_q.active;
        st_d.prdata[read_throttle_pkg::ST_BLOCK]  = mif.block;
        st_d.prdata[read_throttle_pkg::ST_CNTR]   = st_q.dur != 6'h00;
        st_d.prdata[read_throttle_pkg::ST_DUR_LSB +: 6] = st_q.dur;
        // status is read-only: a write there is an error
        st_d.pslverr = pwrite;
      end else begin
        st_d.prdata  = '0;
        st_d.pslverr = 1'b1;
      end
    end

    // byte-lane mask for the write data
    for (int i = 0; i < 4; i++) begin
      bytes[i*8 +: 8] = pstrb[i] ? 8'hFF : 8'h00;
    end

    // access phase completion commits a write
    if (psel && penable && st_q.pready && pwrite && !st_q.pslverr) begin
      if (paddr == read_throttle_pkg::CTRL_LO_OFS) begin
        wr_mask  = {32'h0000_0000, bytes};
        hit_addr = 1'b1;
      end else if (paddr == read_throttle_pkg::CTRL_HI_OFS) begin
        wr_mask  = {bytes, 32'h0000_0000};
        hit_addr = 1'b1;
      end else if (paddr == read_throttle_pkg::SAMPLE_WIN_OFS) begin
        st_d.swin = (st_q.swin & ~bytes) | (pwdata & bytes);
      end
      if (hit_addr) begin
        wr_mask   = wr_mask & read_throttle_pkg::CTRL_WR_MASK;
        st_d.ctrl = (st_q.ctrl & ~wr_mask) | ({pwdata, pwdata} & wr_mask);
      end
    end

    // (R10) counter mechanism runs only in mode 10
    if (mode == read_throttle_pkg::MODE_COUNTER) begin
      // (R13) sampling window restarts volume count
      st_d.swin_cnt = swin_end ? 32'h0000_0000 : st_q.swin_cnt + 32'h0000_0001;
      st_d.gread    = swin_end ? 28'h000_0000 : gread_inc;
      if (reach) begin
        // (R2) load duration in windows
        st_d.dur = dur_mult;
        st_d.hit = 1'b1;
      end else if (swin_end && st_q.dur != 6'h00) begin
        st_d.dur = st_q.dur - 6'h01;
      end
      if (swin_end && !reach) begin
        st_d.hit = 1'b0;
      end
    end else begin
      // (R6) other modes hold the counter mechanism idle
      st_d.swin_cnt = 32'h0000_0000;
      st_d.gread    = 28'h000_0000;
      st_d.dur      = 6'h00;
      st_d.hit      = 1'b0;
    end

    // (R11) start bit low leaves only the other causes
    // (R12) start bit, (R7) thermal level, (R9) ignored otherwise, (R14) 11 idle
    st_d.active = go ||
                  (mode == read_throttle_pkg::MODE_THERMAL && thermal_on) ||
                  (mode == read_throttle_pkg::MODE_COUNTER && st_q.dur != 6'h00);
  end

  // ==========================================================
  // state register
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q      <= '0;
      st_q.ctrl <= read_throttle_pkg::CTRL_RESET;
      st_q.swin <= read_throttle_pkg::SAMPLE_WIN_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs straight from flops
  assign prdata          = st_q.prdata;
  assign pready          = st_q.pready;
  assign pslverr         = st_q.pslverr;
  assign throttle_active = st_q.active;
  // (R4) block from monitor flop
  assign rd_block        = mif.block;

  // ==========================================================
  // checks
  // ==========================================================
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_mode_off_idle: assert property ( // (R6)
    (mode == 2'b00 && !go) |=> !throttle_active)
    else $error("throttle active with mode off");
  a_reserved_idle: assert property ( // (R14)
    (mode == 2'b11 && !go) |=> !throttle_active ##1 mif.hcount == 12'h000)
    else $error("reserved mode throttled");
  a_thermal_follow: assert property ( // (R7)
    (mode == 2'b01 && thermal_on) |=> throttle_active)
    else $error("thermal request did not throttle");
  a_thermal_drop: assert property ( // (R8)
    (mode == 2'b01 && !thermal_on && !go) |=> !throttle_active ##1 mif.hcount == 12'h000)
    else $error("thermal drop did not stop and clear");
  a_thermal_ignored: assert property ( // (R9)
    ($changed(thermal_on) && (mode == 2'h0 || mode == 2'h3) && !go) |=> !throttle_active)
    else $error("thermal input acted outside its mode");
  a_go_start: assert property ( // (R12)
    go |=> throttle_active)
    else $error("start bit did not throttle");
  a_go_stop: assert property ( // (R11)
    ($fell(go) && mode == 2'b00) |=> !throttle_active ##1 !rd_block)
    else $error("clearing start bit did not stop");
  a_thresh_invoke: assert property ( // (R1)
    (mode == 2'b10 && st_q.dur == 6'h00 && !st_q.hit && st_q.gread >= thresh)
      |=> st_q.dur == $past(dur_mult))
    else $error("threshold reach did not load duration");
  a_dur_countdown: assert property ( // (R2)
    (mode == 2'b10 && swin_end && st_q.dur != 6'h00) |=> st_q.dur == $past(st_q.dur) - 6'h01)
    else $error("duration did not count down per window");
  a_counter_active: assert property ( // (R10)
    (mode == 2'b10 && st_q.dur != 6'h00) |=> throttle_active)
    else $error("counter invocation did not throttle");
  a_swin_restart: assert property ( // (R13)
    (mode == 2'b10 && swin_end) |=> st_q.swin_cnt == 32'h0000_0000 && st_q.gread == 28'h000_0000)
    else $error("sampling window did not restart");
  a_apb_ready: assert property (
    (psel && !penable) |=> pready ##1 !pready)
    else $error("apb answer not one access cycle");

  // ==========================================================
  // register bus checks
  // ==========================================================
  // a full-word write lands as written, reserved bits masked off
  a_lo_write_lands: assert property (
    (psel && penable && pready && pwrite && !pslverr && pstrb == 4'hF &&
     paddr == read_throttle_pkg::CTRL_LO_OFS) |=> st_q.ctrl[31:0] == $past(pwdata))
    else $error("low control write lost");
  a_hi_write_lands: assert property (
    (psel && penable && pready && pwrite && !pslverr && pstrb == 4'hF &&
     paddr == read_throttle_pkg::CTRL_HI_OFS)
      |=> st_q.ctrl[63:32] == ($past(pwdata) & read_throttle_pkg::CTRL_WR_MASK[63:32]))
    else $error("high control write lost");
  a_swin_write_lands: assert property ( // (R13)
    (psel && penable && pready && pwrite && !pslverr && pstrb == 4'hF &&
     paddr == read_throttle_pkg::SAMPLE_WIN_OFS) |=> st_q.swin == $past(pwdata))
    else $error("sampling window write lost");

  // status is read-only: refuse a write and leave all settings alone
  a_status_refused: assert property (
    (psel && penable && pready && pwrite && paddr == read_throttle_pkg::STATUS_OFS)
      |-> pslverr ##1 st_q.ctrl == $past(st_q.ctrl) && st_q.swin == $past(st_q.swin))
    else $error("status write not refused");
  // every other address answers with an error and zero data
  a_unmapped_error: assert property (
    (psel && penable && pready &&
     paddr != read_throttle_pkg::CTRL_LO_OFS && paddr != read_throttle_pkg::CTRL_HI_OFS &&
     paddr != read_throttle_pkg::SAMPLE_WIN_OFS && paddr != read_throttle_pkg::STATUS_OFS)
      |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  // settings cannot move between setup and access, so compare live values
  a_lo_readback: assert property (
    (psel && penable && pready && !pwrite && paddr == read_throttle_pkg::CTRL_LO_OFS)
      |-> prdata == st_q.ctrl[31:0])
    else $error("low control read mismatch");
  a_hi_readback: assert property (
    (psel && penable && pready && !pwrite && paddr == read_throttle_pkg::CTRL_HI_OFS)
      |-> prdata == st_q.ctrl[63:32])
    else $error("high control read mismatch");
  a_swin_readback: assert property ( // (R13)
    (psel && penable && pready && !pwrite && paddr == read_throttle_pkg::SAMPLE_WIN_OFS)
      |-> prdata == st_q.swin)
    else $error("sampling window read mismatch");
  // status is a snapshot of the setup cycle, so compare against the past
  a_status_readback: assert property (
    (psel && penable && pready && !pwrite && paddr == read_throttle_pkg::STATUS_OFS)
      |-> prdata[read_throttle_pkg::ST_ACTIVE] == $past(throttle_active) &&
          prdata[read_throttle_pkg::ST_DUR_LSB +: 6] == $past(st_q.dur))
    else $error("status read mismatch");

  // reserved upper bits stay clear whatever software writes
  a_reserved_zero: assert property (
    st_q.ctrl[63:41] == 23'h00_0000)
    else $error("reserved control bits set");
  // an error only ever comes with the answer
  a_err_with_ready: assert property (
    pslverr |-> pready)
    else $error("error without ready");
  // read data must not wander between transfers: software may look late
  a_prdata_holds: assert property (
    !(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside a setup");
  // an idle bus never gets an answer
  a_no_stray_ready: assert property (
    !psel |=> !pready)
    else $error("ready without a transfer");

  // ==========================================================
  // counter mechanism checks
  // ==========================================================
  // leaving mode 10 drops every trace of a counter invocation
  a_counter_idle: assert property ( // (R6)
    mode != 2'h2 |=> st_q.gread == 28'h000_0000 && st_q.dur == 6'h00 && !st_q.hit)
    else $error("counter state kept outside mode 10");
  // one invocation per sampling window: the mark holds to the window end
  a_hit_holds: assert property ( // (R2)
    (mode == 2'h2 && st_q.hit && !swin_end) |=> st_q.hit)
    else $error("invocation mark dropped mid-window");
  a_dur_holds: assert property ( // (R2)
    (mode == 2'h2 && !swin_end && !reach) |=> st_q.dur == $past(st_q.dur))
    else $error("duration moved inside a window");
  a_volume_count: assert property ( // (R10)
    (mode == 2'h2 && !swin_end && rd_hexword && st_q.gread != 28'hFFF_FFFF)
      |=> st_q.gread == $past(st_q.gread) + 28'h000_0001)
    else $error("read volume not counted");
  a_swin_count: assert property ( // (R13)
    (mode == 2'h2 && !swin_end) |=> st_q.swin_cnt == $past(st_q.swin_cnt) + 32'h0000_0001)
    else $error("sampling window not counting");

  // ==========================================================
  // throttle output checks
  // ==========================================================
  // reads are only blocked while throttling was in effect
  a_block_when_active: assert property ( // (R4)
    rd_block |-> $past(throttle_active))
    else $error("reads blocked while not throttling");
  // throttling never shows up without one of its three causes
  a_active_cause: assert property ( // (R12)
    throttle_active |-> $past(go) || ($past(mode) == 2'h1 && $past(thermal_on)) ||
                        ($past(mode) == 2'h2 && $past(st_q.dur) != 6'h00))
    else $error("throttle active without a cause");

  c_go_throttle: cover property (go ##1 throttle_active);
  c_thermal_throttle: cover property (mode == 2'b01 && $rose(thermal_on) ##1 throttle_active);
  c_counter_invoke: cover property (reach ##1 st_q.dur != 6'h00);
  c_read_blocked: cover property ($rose(rd_block));
  c_status_refused: cover property (pslverr && pwrite);

endmodule

/* mem_read_model.sv */
module mem_read_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic demand,
  input  wire logic rd_block,
  output logic      rd_hexword,
  output int        issued
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // read request source
  // ==========================================================
  // one hexword per cycle while there is demand and no block;
  // the block is seen one edge late, as a real requester would
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_hexword <= 1'b0;
      issued     <= 0;
    end else begin
      rd_hexword <= demand && !rd_block;
      if (demand && !rd_block) begin
        issued <= issued + 1;
      end
    end
  end
endmodule

/* dram_read_throttle_tb.sv */
module dram_read_throttle_tb;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [11:0] LO = read_throttle_pkg::CTRL_LO_OFS;
  localparam logic [11:0] HI = read_throttle_pkg::CTRL_HI_OFS;
  localparam logic [11:0] SW = read_throttle_pkg::SAMPLE_WIN_OFS;
  localparam logic [11:0] ST = read_throttle_pkg::STATUS_OFS;

  logic        pclk, presetn, psel, penable, pwrite, thermal_on, demand;
  logic        pready, pslverr, rd_hexword, rd_block, throttle_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0]  pstrb;
  int          n_errors, samples_checked, cyc, t0, t1, k;

  dram_read_throttle dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .thermal_on(thermal_on), .rd_hexword(rd_hexword),
    .rd_block(rd_block), .throttle_active(throttle_active));

  mem_read_model mem (.pclk(pclk), .presetn(presetn), .demand(demand), .rd_block(rd_block),
    .rd_hexword(rd_hexword), .issued(k));

  // ==========================================================
  // clock, cycle count, watchdog
  // ==========================================================
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  always @(posedge pclk) cyc <= cyc + 1;

  // the long threshold run alone takes about 33000 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    n_errors++;
    close_out();
  end

  // ==========================================================
  // helpers
  // ==========================================================
  task automatic chk(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  function automatic logic [31:0] ctl(input logic go, input logic [1:0] md,
    input logic [11:0] cap, input logic [6:0] win, input logic [5:0] dur);
    ctl = {4'h0, dur, win, cap, md, go};
  endfunction

  // one apb transfer; for reads d is the expected value under mask m
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] m, input logic xerr);
    logic e;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= w ? d : 32'h0000_0000;
    @(posedge pclk);
    penable <= 1'b1;
    // answer taken at the rising edge that sees pready; only the watchdog ends a wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat     = prdata;
    e        = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk(e === xerr, "error response");
    if (!w) chk((rdat & m) === (d & m), "read data");
  endtask

  task automatic wait_act(input logic v, input int n);
    int i;
    i = 0;
    while (throttle_active !== v && i < n) begin
      @(negedge pclk);
      i++;
    end
    chk(throttle_active === v, "throttle level");
  endtask

  // neither throttle nor block may show for n cycles
  task automatic quiet(input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      @(negedge pclk);
      if (throttle_active !== 1'b0 || rd_block !== 1'b0) bad = 1'b1;
    end
    chk(!bad, "throttle while idle");
  endtask

  task automatic fall(output int t);
    int i;
    i = 0;
    while (rd_block !== 1'b1 && i < 300) begin
      @(negedge pclk);
      i++;
    end
    while (rd_block === 1'b1 && i < 300) begin
      @(negedge pclk);
      i++;
    end
    t = cyc;
    chk(i < 300, "block edge");
  endtask

  task automatic close_out();
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // test sequence
  // ==========================================================
  initial begin
    {presetn, psel, penable, pwrite, thermal_on, demand} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    n_errors = 0;
    samples_checked = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, reserved bits, refused accesses
    apb(0, LO, 32'h0, 32'hFFFF_FFFF, 0);
    apb(0, HI, 32'h0, 32'hFFFF_FFFF, 0);
    apb(0, SW, 32'h0, 32'hFFFF_FFFF, 0);
    apb(0, ST, 32'h0, 32'hFFFF_FFFF, 0);
    apb(0, 12'h100, 32'h0, 32'hFFFF_FFFF, 1);
    apb(1, ST, 32'h1, 32'h0, 1);
    apb(1, HI, 32'hFFFF_FFFF, 32'h0, 0);
    apb(0, HI, 32'h0000_01FF, 32'hFFFF_FFFF, 0);
    apb(1, HI, 32'h0, 32'h0, 0);
    // software start: window length per field value
    demand <= 1'b1;
    for (int f = 1; f <= 2; f++) begin
      apb(1, LO, ctl(1, 2'h0, 12'h002, f[6:0], 6'h00), 32'h0, 0);
      fall(t0);
      fall(t1);
      chk(t1 - t0 == 16 * f, "window length");
    end
    // cap of two per sixteen-clock window over ten windows
    apb(1, LO, ctl(1, 2'h0, 12'h002, 7'h01, 6'h00), 32'h0, 0);
    fall(t0);
    t1 = k;
    repeat (10) fall(t0);
    chk(k - t1 >= 20 && k - t1 <= 40, "hexwords per window");
    // software stop
    apb(1, LO, ctl(0, 2'h0, 12'h002, 7'h01, 6'h00), 32'h0, 0);
    wait_act(0, 4);
    quiet(40);
    // thermal request mode
    apb(1, LO, ctl(0, 2'h1, 12'h002, 7'h01, 6'h00), 32'h0, 0);
    @(posedge pclk);
    thermal_on <= 1'b1;
    wait_act(1, 4);
    fall(t0);
    @(posedge pclk);
    thermal_on <= 1'b0;
    wait_act(0, 4);
    quiet(20);
    // thermal request ignored in every other mode
    apb(1, HI, 32'h1, 32'h0, 0);
    apb(1, LO, ctl(0, 2'h0, 12'h002, 7'h01, 6'h00), 32'h0, 0);
    @(posedge pclk);
    thermal_on <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      if (m == 1) continue;
      apb(1, LO, ctl(0, m[1:0], 12'h002, 7'h01, 6'h05), 32'h0, 0);
      quiet(30);
    end
    @(posedge pclk);
    thermal_on <= 1'b0;
    // counter mode, zero threshold, twenty-clock sampling window
    apb(1, HI, 32'h0, 32'h0, 0);
    apb(1, SW, 32'h0000_0014, 32'h0, 0);
    apb(1, LO, ctl(0, 2'h2, 12'h002, 7'h01, 6'h00), 32'h0, 0);
    quiet(60);
    apb(1, LO, ctl(0, 2'h0, 12'h002, 7'h01, 6'h00), 32'h0, 0);
    apb(1, LO, ctl(0, 2'h2, 12'h002, 7'h01, 6'h02), 32'h0, 0);
    wait_act(1, 6);
    t0 = cyc;
    apb(0, ST, 32'h4, 32'h4, 0);
    wait_act(0, 45);
    chk(cyc - t0 >= 19 && cyc - t0 <= 42, "duration windows");
    // threshold field one: 32768 hexwords in an endless window
    apb(1, LO, ctl(0, 2'h0, 12'h002, 7'h01, 6'h00), 32'h0, 0);
    apb(1, SW, 32'hFFFF_FFFF, 32'h0, 0);
    apb(1, LO, ctl(0, 2'h2, 12'h002, 7'h01, 6'h01) | 32'h1000_0000, 32'h0, 0);
    quiet(32700);
    wait_act(1, 200);
    close_out();
  end
endmodule
